// *** core/ppsb_port_power.sv ***
// Port power, over-current reporting and PCIe sideband control with APB registers
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
//
// What this block does
// - Over-current input low means over-current present; high means none.
// - Port power output high turns supply on, low turns it off.
// - Power asserts only after max-slots write or host reset set, not link reset.
// - Wake output pulled low open-drain to request power and clock back.
// - Clock request output open-drain low tells whether reference clock should run.
module ppsb_port_power
    import ppsb_pkg::*;
#(
    parameter int NUM_PORTS = 4
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 clk_en,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 link_reset_in_n,
    input  wire logic [NUM_PORTS-1:0] over_current_in_n,
    output logic      [NUM_PORTS-1:0] port_power_out,
    output logic                      wake_request_out_n,
    output logic                      wake_request_oe,
    output logic                      refclk_request_out_n,
    output logic                      refclk_request_oe,
    output logic                      irq
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (NUM_PORTS < 1 || NUM_PORTS > PPSB_MAX_PORTS) begin : g_bad_ports
        $error("NUM_PORTS must be 1 to 4");
    end

    // Event and status fields must not overlap the per-port bits
    if (PPSB_PSTAT_ARMED_BIT < NUM_PORTS || PPSB_IRQ_REL_LSB < NUM_PORTS) begin : g_bad_layout
        $error("Status fields overlap for this port count");
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [PPSB_CTRL_MAXSLOTS_W-1:0] max_slots_enable_field_reg, max_slots_enable_field_next;
    logic                 armed_reg,   armed_next;
    logic                 wake_reg,    wake_next;
    logic                 clkrun_reg,  clkrun_next;
    logic [NUM_PORTS-1:0] pwren_reg,   pwren_next;
    logic [NUM_PORTS-1:0] oc_reg,      oc_next;
    logic [NUM_PORTS-1:0] oc_set_reg,  oc_set_next;
    logic [NUM_PORTS-1:0] oc_rel_reg,  oc_rel_next;
    logic [NUM_PORTS-1:0] msk_set_reg, msk_set_next;
    logic [NUM_PORTS-1:0] msk_rel_reg, msk_rel_next;
    logic [NUM_PORTS-1:0] pp_reg,      pp_next;
    logic [31:0]          rdata_reg,   rdata_next;

    // ------------------------------------------------------------------
    // Bus decode and helpers
    // ------------------------------------------------------------------
    ppsb_req_s req;
    logic      wr_acc;
    logic      rd_acc;
    logic [NUM_PORTS-1:0] oc_now;

    function automatic logic [NUM_PORTS-1:0] w1c(input logic [NUM_PORTS-1:0] cur,
                                                 input logic [NUM_PORTS-1:0] ev,
                                                 input logic [NUM_PORTS-1:0] clr);
        // Set wins over a simultaneous clear so no event is lost
        return (cur & ~clr) | ev;
    endfunction

    function automatic logic decoded(input logic [7:0] a);
        return a == PPSB_OFF_CTRL || a == PPSB_OFF_PSTAT || a == PPSB_OFF_ISTAT
            || a == PPSB_OFF_IMASK || a == PPSB_OFF_PWREN;
    endfunction

    assign req    = '{addr: paddr, write: pwrite, wdata: pwdata};
    assign wr_acc = clk_en && psel && penable && req.write;
    // Captured in setup so the access cycle can answer at once
    assign rd_acc = clk_en && psel && !penable && !req.write;
    assign oc_now = ~over_current_in_n;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        max_slots_enable_field_next = max_slots_enable_field_reg;
        armed_next   = armed_reg;
        wake_next    = wake_reg;
        clkrun_next  = clkrun_reg;
        pwren_next   = pwren_reg;
        msk_set_next = msk_set_reg;
        msk_rel_next = msk_rel_reg;
        rdata_next   = rdata_reg;
        // Pin level is registered once; edges are found against that copy
        oc_next      = oc_now;
        oc_set_next  = w1c(oc_set_reg, oc_now & ~oc_reg, '0);
        oc_rel_next  = w1c(oc_rel_reg, ~oc_now & oc_reg, '0);

        if (wr_acc) begin
            case (req.addr)
                PPSB_OFF_CTRL: begin
                    max_slots_enable_field_next =
                        req.wdata[PPSB_CTRL_MAXSLOTS_LSB +: PPSB_CTRL_MAXSLOTS_W];
                    // Any max-slots write or host reset arms power
                    armed_next  = 1'b1;
                    wake_next   = req.wdata[PPSB_CTRL_WAKE_BIT];
                    clkrun_next = req.wdata[PPSB_CTRL_CLKRUN_BIT];
                end
                PPSB_OFF_ISTAT: begin
                    oc_set_next = w1c(oc_set_reg, oc_now & ~oc_reg,
                                      req.wdata[NUM_PORTS-1:0]);
                    oc_rel_next = w1c(oc_rel_reg, ~oc_now & oc_reg,
                                      req.wdata[PPSB_IRQ_REL_LSB +: NUM_PORTS]);
                end
                PPSB_OFF_IMASK: begin
                    msk_set_next = req.wdata[NUM_PORTS-1:0];
                    msk_rel_next = req.wdata[PPSB_IRQ_REL_LSB +: NUM_PORTS];
                end
                // Enable only gates the output; the armed state still rules
                PPSB_OFF_PWREN: pwren_next = req.wdata[NUM_PORTS-1:0];
                default: ;
            endcase
        end

        // Unmapped reads return zero; the bus error flag marks them
        if (rd_acc) begin
            rdata_next = PPSB_RST_ZERO;
            case (req.addr)
                PPSB_OFF_CTRL: begin
                    rdata_next[PPSB_CTRL_MAXSLOTS_LSB +: PPSB_CTRL_MAXSLOTS_W] =
                        max_slots_enable_field_reg;
                    rdata_next[PPSB_CTRL_WAKE_BIT]   = wake_reg;
                    rdata_next[PPSB_CTRL_CLKRUN_BIT] = clkrun_reg;
                end
                PPSB_OFF_PSTAT: begin
                    rdata_next[NUM_PORTS-1:0]        = oc_reg;
                    rdata_next[PPSB_PSTAT_ARMED_BIT] = armed_reg;
                end
                PPSB_OFF_ISTAT: begin
                    rdata_next[NUM_PORTS-1:0]                 = oc_set_reg;
                    rdata_next[PPSB_IRQ_REL_LSB +: NUM_PORTS] = oc_rel_reg;
                end
                PPSB_OFF_IMASK: begin
                    rdata_next[NUM_PORTS-1:0]                 = msk_set_reg;
                    rdata_next[PPSB_IRQ_REL_LSB +: NUM_PORTS] = msk_rel_reg;
                end
                PPSB_OFF_PWREN: rdata_next[NUM_PORTS-1:0] = pwren_reg;
                default: ;
            endcase
        end

        // Link reset disarms; re-arming needs software again, not reset release
        if (!link_reset_in_n) begin
            armed_next = 1'b0;
        end
        // Hardware follows the power switch report: off while over-current
        pp_next = (armed_next && link_reset_in_n)
                ? (pwren_next & ~oc_now) : '0;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            max_slots_enable_field_reg <= '0;
            armed_reg   <= 1'b0;
            wake_reg    <= 1'b0;
            // Clock wanted from reset so the link can come up
            clkrun_reg  <= 1'b1;
            pwren_reg   <= PPSB_RST_PWREN[NUM_PORTS-1:0];
            oc_reg      <= '0;
            oc_set_reg  <= '0;
            oc_rel_reg  <= '0;
            msk_set_reg <= '0;
            msk_rel_reg <= '0;
            pp_reg      <= '0;
            rdata_reg   <= PPSB_RST_ZERO;
        end else if (clk_en) begin
            max_slots_enable_field_reg <= max_slots_enable_field_next;
            armed_reg   <= armed_next;
            wake_reg    <= wake_next;
            clkrun_reg  <= clkrun_next;
            pwren_reg   <= pwren_next;
            oc_reg      <= oc_next;
            oc_set_reg  <= oc_set_next;
            oc_rel_reg  <= oc_rel_next;
            msk_set_reg <= msk_set_next;
            msk_rel_reg <= msk_rel_next;
            pp_reg      <= pp_next;
            rdata_reg   <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Read data is registered in setup, so every access finishes in one access cycle
    assign pready         = 1'b1;
    assign prdata         = rdata_reg;
    // Error is flagged only while the access phase stands
    assign pslverr        = psel && penable && !decoded(req.addr);
    assign port_power_out = pp_reg;
    // Level output: stays high until software clears or masks the source
    assign irq = |((oc_set_reg & msk_set_reg) | (oc_rel_reg & msk_rel_reg));

    // Open drain: output value always low, the enable pulls the wire
    assign wake_request_out_n   = 1'b0;
    assign wake_request_oe      = wake_reg;
    assign refclk_request_out_n = 1'b0;
    assign refclk_request_oe    = clkrun_reg;

endmodule // ppsb_port_power

// *** core/ppsb_pkg.sv ***
// Package for the port power and PCIe sideband block: offsets, fields, types
package ppsb_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] PPSB_OFF_CTRL   = 8'h00;
    localparam logic [7:0] PPSB_OFF_PSTAT  = 8'h04;
    localparam logic [7:0] PPSB_OFF_ISTAT  = 8'h08;
    localparam logic [7:0] PPSB_OFF_IMASK  = 8'h0C;
    localparam logic [7:0] PPSB_OFF_PWREN  = 8'h10;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int PPSB_CTRL_MAXSLOTS_LSB = 0;
    localparam int PPSB_CTRL_MAXSLOTS_W   = 8;
    localparam int PPSB_CTRL_HCRST_BIT    = 8;
    localparam int PPSB_CTRL_WAKE_BIT     = 9;
    localparam int PPSB_CTRL_CLKRUN_BIT   = 10;

    // Status register layout: over-current level in low nibble, armed flag above
    localparam int PPSB_PSTAT_ARMED_BIT   = 8;

    // Interrupt status: per-port over-current assert events in low bits,
    // per-port over-current release events starting at this bit
    localparam int PPSB_IRQ_REL_LSB       = 4;
    localparam int PPSB_MAX_PORTS         = 4;

    localparam logic [31:0] PPSB_RST_ZERO  = 32'h0000_0000;
    localparam logic [31:0] PPSB_RST_PWREN = 32'h0000_000F;

    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
        logic [31:0] wdata;
    } ppsb_req_s;

endpackage : ppsb_pkg

// *** testbench/ppsb_switch_model.sv ***
// Behavioural model of the port power switches and the host-side sideband wires
`timescale 1ns/1ps
module ppsb_switch_model #(
    parameter int NUM_PORTS = 4
) (
    input  wire logic [NUM_PORTS-1:0] fault,
    input  wire logic                 wake_request_out_n,
    input  wire logic                 wake_request_oe,
    input  wire logic                 refclk_request_out_n,
    input  wire logic                 refclk_request_oe,
    output logic      [NUM_PORTS-1:0] over_current_in_n,
    output logic                      wake_wire,
    output logic                      clkreq_wire
);
    // Switch flag is a level held low for as long as the short lasts
    assign over_current_in_n = ~fault;
    // Host board pulls both open-drain wires up when nobody sinks them
    assign wake_wire   = wake_request_oe ? wake_request_out_n : 1'b1;
    // Host keeps the reference clock running while this wire is low
    assign clkreq_wire = refclk_request_oe ? refclk_request_out_n : 1'b1;
endmodule // ppsb_switch_model

// *** testbench/ppsb_port_power_properties.sv ***
// Concurrent checks on the ports of the port power and sideband block
`timescale 1ns/1ps
module ppsb_port_power_properties
    import ppsb_pkg::*;
#(
    parameter int NUM_PORTS = 4
) (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 clk_en,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 link_reset_in_n,
    input wire logic [NUM_PORTS-1:0] over_current_in_n,
    input wire logic [NUM_PORTS-1:0] port_power_out,
    input wire logic                 wake_request_oe,
    input wire logic                 refclk_request_oe
);
    logic wr_ctrl;
    logic arm_reg;
    logic arm_next;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr_ctrl = clk_en && psel && penable && pwrite && paddr == PPSB_OFF_CTRL;
    // Shadow of the power-up permission; a link reset withdraws it
    always_comb arm_next = (clk_en && !link_reset_in_n) ? 1'b0 : (wr_ctrl || arm_reg);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) arm_reg <= 1'b0;
        else arm_reg <= arm_next;
    end
    power_needs_arm_a: assert property (|port_power_out |-> arm_reg)
        else $error("port power on without software enable");
    link_cuts_power_a: assert property (clk_en && !link_reset_in_n |=> port_power_out == '0)
        else $error("port power on during link reset");
    // Two samples of fault so either input pipelining choice is accepted
    oc_cuts_power_a: assert property (clk_en && $past(clk_en) |=>
        (port_power_out & ~$past(over_current_in_n) & ~$past(over_current_in_n, 2)) == '0)
        else $error("port power kept on during over-current");
    wake_pull_a: assert property (wr_ctrl && pwdata[PPSB_CTRL_WAKE_BIT] |=> wake_request_oe)
        else $error("wake wire not pulled after request");
    clkreq_free_a: assert property (
        wr_ctrl && !pwdata[PPSB_CTRL_CLKRUN_BIT] |=> !refclk_request_oe)
        else $error("clock request still pulled after release");
    sideband_hold_a: assert property (
        clk_en && !wr_ctrl |=> $stable({wake_request_oe, refclk_request_oe}))
        else $error("sideband output changed without a control write");
endmodule // ppsb_port_power_properties
bind ppsb_port_power ppsb_port_power_properties #(.NUM_PORTS(NUM_PORTS)) u_props (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .link_reset_in_n,
    .over_current_in_n, .port_power_out, .wake_request_oe, .refclk_request_oe
);

// *** testbench/test_ppsb_port_power.sv ***
// Self-checking bench for the port power and PCIe sideband block
`timescale 1ns/1ps
module test_ppsb_port_power import ppsb_pkg::*;;
    localparam int NP = 4;
    logic          pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq;
    logic          link_reset_in_n, wake_request_out_n, wake_request_oe, wake_wire;
    logic          refclk_request_out_n, refclk_request_oe, clkreq_wire;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, r;
    logic [31:0]   seed = 32'h67841E4A;
    logic [NP-1:0] port_power_out, fault, over_current_in_n;
    logic [31:0]   exp_q[$];
    int            n_fail = 0, total_checks = 0;
    ppsb_port_power #(.NUM_PORTS(NP)) dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .link_reset_in_n, .over_current_in_n,
        .port_power_out, .wake_request_out_n, .wake_request_oe, .refclk_request_out_n,
        .refclk_request_oe, .irq);
    ppsb_switch_model #(.NUM_PORTS(NP)) u_sw (.fault, .wake_request_out_n, .wake_request_oe,
        .refclk_request_out_n, .refclk_request_oe, .over_current_in_n, .wake_wire, .clkreq_wire);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(a, 1'b0, '0);
    endtask
    // Read results are judged where they appear, against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && clk_en) begin
            chk("prdata", prdata, exp_q.pop_front());
            chk("pslverr", pslverr, paddr > PPSB_OFF_PWREN);
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        end_sim();
    end
    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        link_reset_in_n = 1'b0;
        fault = '0;
        cyc(20);
        presetn <= 1'b1;
        cyc(2);
        chk("power", port_power_out, '0);
        chk("clkreq", clkreq_wire, 1'b0);
        link_reset_in_n <= 1'b1;
        cyc(4);
        chk("power", port_power_out, '0);
        rd(PPSB_OFF_PWREN, PPSB_RST_PWREN);
        r = 32'h400 | (rnd() & 32'hFF);
        apb(PPSB_OFF_CTRL, 1'b1, r);
        cyc(2);
        chk("power", port_power_out, 32'hF);
        rd(PPSB_OFF_CTRL, r);
        rd(PPSB_OFF_PSTAT, 32'h1 << PPSB_PSTAT_ARMED_BIT);
        r = rnd() & 32'hF;
        apb(PPSB_OFF_PWREN, 1'b1, r);
        chk("power", port_power_out, r);
        apb(PPSB_OFF_PWREN, 1'b1, 32'hF);
        apb(PPSB_OFF_IMASK, 1'b1, 32'hFF);
        for (int p = 0; p < NP; p++) begin
            fault[p] <= 1'b1;
            cyc(3);
            chk("power", port_power_out, 32'hF & ~(32'h1 << p));
            chk("irq", irq, 1'b1);
            fault[p] <= 1'b0;
            cyc(3);
            rd(PPSB_OFF_ISTAT, 32'h11 << p);
            apb(PPSB_OFF_ISTAT, 1'b1, 32'hFF);
            chk("irq", irq, 1'b0);
        end
        apb(PPSB_OFF_CTRL, 1'b1, 32'h200);
        chk("wake", wake_wire, 1'b0);
        chk("clkreq", clkreq_wire, 1'b1);
        apb(PPSB_OFF_CTRL, 1'b1, 32'h400);
        chk("wake", wake_wire, 1'b1);
        chk("clkreq", clkreq_wire, 1'b0);
        clk_en <= 1'b0;
        apb(PPSB_OFF_PWREN, 1'b1, 32'h0);
        clk_en <= 1'b1;
        cyc(2);
        chk("power", port_power_out, 32'hF);
        link_reset_in_n <= 1'b0;
        cyc(3);
        chk("power", port_power_out, '0);
        link_reset_in_n <= 1'b1;
        cyc(3);
        chk("power", port_power_out, '0);
        rd(PPSB_OFF_PSTAT, '0);
        rd(8'h14, '0);
        end_sim();
    end
endmodule // test_ppsb_port_power
